// file: logic/tmh_pkg.sv
// Package: constants and types for the transmitter mode, hold and trend controller
package tmh_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned LONG_PRESS_MS  = 2000;
  localparam int unsigned LONG_PRESS_CYC = (CLK_HZ / 1000) * LONG_PRESS_MS;
  localparam int unsigned CHART_DIV_S    = 15;
  localparam int unsigned CHART_DIVS     = 12;
  localparam int unsigned CHART_DIV_CYC  = CLK_HZ * CHART_DIV_S;

  // ----------------------------------------
  // Trend layout
  // ----------------------------------------
  localparam int unsigned TREND_GROUPS     = 60;
  localparam int unsigned TREND_AXIS_DIVS  = 12;
  localparam int unsigned GROUPS_PER_DIV   = TREND_GROUPS / TREND_AXIS_DIVS;
  localparam int unsigned TREND_MIN_MIN    = 3;
  localparam int unsigned TREND_MAX_MIN    = 40320;
  localparam int unsigned MIN_PER_HOUR     = 60;

  // ----------------------------------------
  // Factory defaults (fixed-point, unit scaled as noted)
  // ----------------------------------------
  localparam logic [15:0] DEF_MTC_TEMP_X10   = 16'h00FA; // 25.0 C
  localparam logic [15:0] DEF_TC_X100        = 16'h00C8; // 2.00 %
  localparam logic [15:0] DEF_R1_SP_X100     = 16'h2710; // 100.00 mS
  localparam logic [15:0] DEF_R1_DB_X100     = 16'h03E8; // 10.00 mS
  localparam logic [15:0] DEF_R2_SP_X100     = 16'h03E8; // 10.00 mS
  localparam logic [15:0] DEF_R2_DB_X100     = 16'h0064; // 1.00 mS
  localparam logic [15:0] DEF_AO1_HI_X10     = 16'h07CF; // 199.9 mS
  localparam logic [15:0] DEF_AO2_HI_X10     = 16'h03E8; // 100.0 C
  localparam logic [15:0] DEF_CELL_X10000    = 16'h1388; // 0.5000
  localparam logic [15:0] DEF_SETUP_CODE     = 16'h1111;
  localparam logic [15:0] DEF_CAL_CODE       = 16'h1100;

  // ----------------------------------------
  // Modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    TMH_POWERUP = 3'b000,
    TMH_MEASURE = 3'b001,
    TMH_LOGVIEW = 3'b010,
    TMH_SETUP   = 3'b011,
    TMH_CALIB   = 3'b100
  } tmh_mode_type;

  typedef enum logic [1:0] {
    TMH_DISP_DIGITS = 2'b00,
    TMH_DISP_CHART  = 2'b01,
    TMH_DISP_TREND  = 2'b10
  } tmh_disp_type;

endpackage : tmh_pkg

// file: logic/tmh_ctrl.sv
// Module: transmitter mode, shortcut, hold, chart and trend supervisory logic
`timescale 1ns/10ps
// How it works
// - Power-up enters measurement with stored settings
// - Log key held 2 s opens log
// - Display key held 2 s steps views
// - Chart spans 12 divisions of 15 s
// - Chart restarts after set-up or calibration
// - Out-of-range chart readings clamp to limits
// - Trend duration 3 min to 672:00
// - Sixty groups of mean, max, min
// - New group enters right, older shift left
// - Axis of 12 divisions, 5 groups each
// - Interval change discards trend record
// - Cleaning shows message, lights LED, blocks relays
// - Relay trip lights LED, names relay
// - Hold during cleaning, set-up, calibration
// - Hold stops relays; set-up ends cleaning
// - Current output frozen under hold
// - Serial value frozen under hold
// - Master reset loads measurement defaults
// - Master reset loads relay defaults
// - Master reset loads output spans
// - Calibration reset loads uncalibrated defaults
// - Set-up code 1111 also opens calibration
module tmh_ctrl #(
  parameter int unsigned LONG_PRESS_CYC = tmh_pkg::LONG_PRESS_CYC,
  parameter int unsigned CHART_DIV_CYC  = tmh_pkg::CHART_DIV_CYC,
  parameter int unsigned CYC_PER_MIN    = tmh_pkg::CLK_HZ * 60
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Keypad pins (asynchronous)
  input  wire logic        log_key,
  input  wire logic        disp_key,
  input  wire logic        setup_req,
  input  wire logic        calib_req,
  input  wire logic        exit_req,
  input  wire logic [15:0] code_entry,
  input  wire logic        code_enable,
  // Reset commands and trend setting
  input  wire logic        master_reset,
  input  wire logic        calib_reset,
  input  wire logic [15:0] trend_minutes,
  // Measurement and relay inputs
  input  wire logic [15:0] reading,
  input  wire logic        reading_valid,
  input  wire logic [15:0] chart_lo,
  input  wire logic [15:0] chart_hi,
  input  wire logic        clean_active,
  input  wire logic        relay_one_trip,
  input  wire logic        relay_two_trip,
  input  wire logic        relay_one_high,
  input  wire logic        relay_two_high,
  input  wire logic [15:0] analog_live,
  // Mode and display
  output tmh_pkg::tmh_mode_type mode,
  output tmh_pkg::tmh_disp_type disp,
  output logic             hold,
  output logic             clean_stop,
  output logic             clean_msg,
  output logic             activity_led,
  output logic             relay_one_high_msg,
  output logic             relay_one_low_msg,
  output logic             relay_two_high_msg,
  output logic             relay_two_low_msg,
  output logic             relay_one_out,
  output logic             relay_two_out,
  // Frozen outputs
  output logic [15:0]      analog_out,
  output logic [15:0]      serial_value,
  // Chart point
  output logic [15:0]      chart_point,
  output logic             chart_restart,
  output logic [3:0]       chart_div,
  // Trend
  output logic [9:0]       trend_hours,
  output logic [5:0]       trend_mins,
  output logic [15:0]      trend_mean [tmh_pkg::TREND_GROUPS],
  output logic [15:0]      trend_max  [tmh_pkg::TREND_GROUPS],
  output logic [15:0]      trend_min  [tmh_pkg::TREND_GROUPS],
  output logic [5:0]       trend_fill,
  output logic             trend_div_mark,
  // Stored configuration
  output logic             cfg_cond_auto,
  output logic             manual_temp_comp,
  output logic [15:0]      mtc_temp,
  output logic [15:0]      temp_coef,
  output logic [15:0]      relay_one_setpoint,
  output logic [15:0]      relay_two_setpoint,
  output logic [15:0]      relay_one_dead_band,
  output logic [15:0]      relay_two_dead_band,
  output logic             relay_one_is_high,
  output logic             relay_two_is_high,
  output logic             wash_on,
  output logic             backlight_on,
  output logic [3:0]       contrast,
  output logic             code_on,
  output logic             auto_return,
  output logic             ao_four_ma,
  output logic [15:0]      ao1_span_hi,
  output logic [15:0]      ao2_span_hi,
  output logic             calibrated,
  output logic [15:0]      cal_temp,
  output logic             cal_date_reset,
  output logic [15:0]      cell_const,
  output logic [15:0]      setup_code
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
    end else begin
      sync_a <= {code_enable, exit_req, calib_req, setup_req, disp_key, log_key, clean_active};
      sync_b <= sync_a;
    end
  end
  logic clean_s, log_s, disp_s, setup_s, calib_s, exit_s, code_s;
  assign {code_s, exit_s, calib_s, setup_s, disp_s, log_s, clean_s} = sync_b;

  // Long-press detection shared by both keys
  function automatic logic [31:0] press_count(input logic key, input logic [31:0] cnt);
    press_count = key ? ((cnt == 32'hFFFF_FFFF) ? cnt : cnt + 32'h1) : 32'h0;
  endfunction : press_count

  logic [31:0] log_cnt;
  logic [31:0] disp_cnt;
  logic        log_prev;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      log_cnt  <= 32'h0;
      disp_cnt <= 32'h0;
      log_prev <= 1'b0;
    end else begin
      log_cnt  <= press_count(log_s, log_cnt);
      disp_cnt <= press_count(disp_s, disp_cnt);
      log_prev <= log_s;
    end
  end
  logic log_long, disp_long, log_press;
  assign log_long  = log_s && (log_cnt == LONG_PRESS_CYC - 1);
  assign disp_long = disp_s && (disp_cnt == LONG_PRESS_CYC - 1);
  assign log_press = log_s && !log_prev;

  // ----------------------------------------
  // Mode machine
  // ----------------------------------------
  // Set-up code is accepted for calibration too, so it takes precedence
  logic code_ok_setup, code_ok_calib;
  assign code_ok_setup = !code_s || (code_entry == setup_code);
  assign code_ok_calib = code_ok_setup || (code_entry == tmh_pkg::DEF_CAL_CODE);

  tmh_pkg::tmh_mode_type next_mode;
  always_comb begin
    next_mode = mode;
    case (mode)
      tmh_pkg::TMH_POWERUP: next_mode = tmh_pkg::TMH_MEASURE;
      tmh_pkg::TMH_MEASURE: begin
        if (setup_s && code_ok_setup) next_mode = tmh_pkg::TMH_SETUP;
        else if (calib_s && code_ok_calib) next_mode = tmh_pkg::TMH_CALIB;
        else if (log_long) next_mode = tmh_pkg::TMH_LOGVIEW;
      end
      tmh_pkg::TMH_LOGVIEW: if (log_press) next_mode = tmh_pkg::TMH_MEASURE;
      tmh_pkg::TMH_SETUP,
      tmh_pkg::TMH_CALIB:   if (exit_s) next_mode = tmh_pkg::TMH_MEASURE;
      default:              next_mode = tmh_pkg::TMH_MEASURE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) mode <= tmh_pkg::TMH_POWERUP;
    else     mode <= next_mode;
  end

  // Display view steps only from measurement
  always_ff @(posedge clk or posedge rst) begin
    if (rst) disp <= tmh_pkg::TMH_DISP_DIGITS;
    else if (mode == tmh_pkg::TMH_MEASURE && disp_long) begin
      case (disp)
        tmh_pkg::TMH_DISP_DIGITS: disp <= tmh_pkg::TMH_DISP_CHART;
        tmh_pkg::TMH_DISP_CHART:  disp <= tmh_pkg::TMH_DISP_TREND;
        default:                  disp <= tmh_pkg::TMH_DISP_DIGITS;
      endcase
    end
  end

  // ----------------------------------------
  // Hold, cleaning and relays
  // ----------------------------------------
  logic in_menu;
  assign in_menu    = (mode == tmh_pkg::TMH_SETUP) || (mode == tmh_pkg::TMH_CALIB);
  assign clean_stop = in_menu;
  assign clean_msg  = clean_s && !in_menu;
  assign hold       = clean_msg || in_menu;
  assign relay_one_out = relay_one_trip && !hold;
  assign relay_two_out = relay_two_trip && !hold;
  assign relay_one_high_msg = relay_one_out && relay_one_high;
  assign relay_one_low_msg  = relay_one_out && !relay_one_high;
  assign relay_two_high_msg = relay_two_out && relay_two_high;
  assign relay_two_low_msg  = relay_two_out && !relay_two_high;
  assign activity_led = clean_msg || relay_one_out || relay_two_out;

  // Outputs track live values and freeze while hold stands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      analog_out   <= 16'h0000;
      serial_value <= 16'h0000;
    end else if (!hold) begin
      analog_out <= analog_live;
      if (reading_valid) serial_value <= reading;
    end
  end

  // ----------------------------------------
  // Real-time chart
  // ----------------------------------------
  logic [31:0] chart_cnt;
  assign chart_restart = in_menu && (next_mode == tmh_pkg::TMH_MEASURE);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chart_cnt <= 32'h0;
      chart_div <= 4'h0;
    end else if (chart_restart) begin
      chart_cnt <= 32'h0;
      chart_div <= 4'h0;
    end else if (chart_cnt == CHART_DIV_CYC - 1) begin
      chart_cnt <= 32'h0;
      chart_div <= (chart_div == 4'(tmh_pkg::CHART_DIVS - 1)) ? 4'h0 : chart_div + 4'h1;
    end else begin
      chart_cnt <= chart_cnt + 32'h1;
    end
  end

  // Clamp keeps out-of-range points on the limit lines
  always_ff @(posedge clk or posedge rst) begin
    if (rst) chart_point <= 16'h0000;
    else if (reading_valid) begin
      if (reading > chart_hi)      chart_point <= chart_hi;
      else if (reading < chart_lo) chart_point <= chart_lo;
      else                         chart_point <= reading;
    end
  end

  // ----------------------------------------
  // Trend record
  // ----------------------------------------
  // Out-of-range settings are clamped rather than refused
  logic [15:0] t_min;
  assign t_min = (trend_minutes < 16'(tmh_pkg::TREND_MIN_MIN)) ? 16'(tmh_pkg::TREND_MIN_MIN) :
                 (trend_minutes > 16'(tmh_pkg::TREND_MAX_MIN)) ? 16'(tmh_pkg::TREND_MAX_MIN) :
                 trend_minutes;
  assign trend_hours = 10'(t_min / 16'(tmh_pkg::MIN_PER_HOUR));
  assign trend_mins  = 6'(t_min % 16'(tmh_pkg::MIN_PER_HOUR));

  // Group length T/60 in cycles
  logic [47:0] group_len;
  assign group_len = 48'(t_min) * 48'(CYC_PER_MIN / tmh_pkg::TREND_GROUPS);

  logic [15:0] t_prev;
  logic [47:0] grp_cnt;
  logic [31:0] acc_sum;
  logic [15:0] acc_cnt;
  logic [15:0] acc_max;
  logic [15:0] acc_min;
  logic [7:0]  group_idx;
  logic        t_changed, grp_done;
  assign t_changed = (t_prev != t_min);
  assign grp_done  = (grp_cnt >= group_len - 48'h1);
  assign trend_div_mark = (group_idx % 8'(tmh_pkg::GROUPS_PER_DIV)) == 8'h00;

  // Interval timer and accumulators
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t_prev  <= 16'h0000;
      grp_cnt <= 48'h0;
      acc_sum <= 32'h0;
      acc_cnt <= 16'h0000;
      acc_max <= 16'h0000;
      acc_min <= 16'hFFFF;
    end else begin
      t_prev <= t_min;
      if (t_changed || grp_done) begin
        grp_cnt <= 48'h0;
        acc_sum <= 32'h0;
        acc_cnt <= 16'h0000;
        acc_max <= 16'h0000;
        acc_min <= 16'hFFFF;
      end else begin
        grp_cnt <= grp_cnt + 48'h1;
        if (reading_valid && acc_cnt != 16'hFFFF) begin
          acc_sum <= acc_sum + 32'(reading);
          acc_cnt <= acc_cnt + 16'h0001;
          if (reading > acc_max) acc_max <= reading;
          if (reading < acc_min) acc_min <= reading;
        end
      end
    end
  end

  // Group store: newest at the right end, the rest move left
  logic [15:0] grp_mean;
  assign grp_mean = (acc_cnt == 16'h0000) ? 16'h0000 : 16'(acc_sum / 32'(acc_cnt));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trend_fill <= 6'h00;
      group_idx  <= 8'h00;
      for (int i = 0; i < tmh_pkg::TREND_GROUPS; i++) begin
        trend_mean[i] <= 16'h0000;
        trend_max[i]  <= 16'h0000;
        trend_min[i]  <= 16'h0000;
      end
    end else if (t_changed || master_reset) begin
      trend_fill <= 6'h00;
      group_idx  <= 8'h00;
      for (int i = 0; i < tmh_pkg::TREND_GROUPS; i++) begin
        trend_mean[i] <= 16'h0000;
        trend_max[i]  <= 16'h0000;
        trend_min[i]  <= 16'h0000;
      end
    end else if (grp_done) begin
      for (int i = 0; i < tmh_pkg::TREND_GROUPS - 1; i++) begin
        trend_mean[i] <= trend_mean[i+1];
        trend_max[i]  <= trend_max[i+1];
        trend_min[i]  <= trend_min[i+1];
      end
      trend_mean[tmh_pkg::TREND_GROUPS-1] <= grp_mean;
      trend_max[tmh_pkg::TREND_GROUPS-1]  <= acc_max;
      trend_min[tmh_pkg::TREND_GROUPS-1]  <= acc_min;
      if (trend_fill != 6'(tmh_pkg::TREND_GROUPS)) trend_fill <= trend_fill + 6'h01;
      group_idx <= (group_idx == 8'(tmh_pkg::TREND_GROUPS - 1)) ? 8'h00 : group_idx + 8'h01;
    end
  end

  // ----------------------------------------
  // Factory defaults
  // ----------------------------------------
  // Reset images only; menus edit elsewhere
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_cond_auto <= 1'b1; manual_temp_comp <= 1'b1;
      mtc_temp <= tmh_pkg::DEF_MTC_TEMP_X10; temp_coef <= tmh_pkg::DEF_TC_X100;
      relay_one_setpoint <= tmh_pkg::DEF_R1_SP_X100; relay_one_dead_band <= tmh_pkg::DEF_R1_DB_X100;
      relay_two_setpoint <= tmh_pkg::DEF_R2_SP_X100; relay_two_dead_band <= tmh_pkg::DEF_R2_DB_X100;
      relay_one_is_high <= 1'b1; relay_two_is_high <= 1'b0;
      wash_on <= 1'b0; backlight_on <= 1'b0; contrast <= 4'h0; code_on <= 1'b0;
      auto_return <= 1'b1; ao_four_ma <= 1'b1;
      ao1_span_hi <= tmh_pkg::DEF_AO1_HI_X10; ao2_span_hi <= tmh_pkg::DEF_AO2_HI_X10;
      setup_code <= tmh_pkg::DEF_SETUP_CODE;
    end else if (master_reset) begin
      cfg_cond_auto <= 1'b1; manual_temp_comp <= 1'b1;
      mtc_temp <= tmh_pkg::DEF_MTC_TEMP_X10; temp_coef <= tmh_pkg::DEF_TC_X100;
      relay_one_setpoint <= tmh_pkg::DEF_R1_SP_X100; relay_one_dead_band <= tmh_pkg::DEF_R1_DB_X100;
      relay_two_setpoint <= tmh_pkg::DEF_R2_SP_X100; relay_two_dead_band <= tmh_pkg::DEF_R2_DB_X100;
      relay_one_is_high <= 1'b1; relay_two_is_high <= 1'b0;
      wash_on <= 1'b0; backlight_on <= 1'b0; contrast <= 4'h0; code_on <= 1'b0;
      auto_return <= 1'b1; ao_four_ma <= 1'b1;
      ao1_span_hi <= tmh_pkg::DEF_AO1_HI_X10; ao2_span_hi <= tmh_pkg::DEF_AO2_HI_X10;
      setup_code <= tmh_pkg::DEF_SETUP_CODE;
    end
  end

  // Calibration reset image
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      calibrated <= 1'b0; cal_temp <= 16'h0000; cal_date_reset <= 1'b0;
      cell_const <= tmh_pkg::DEF_CELL_X10000;
    end else begin
      cal_date_reset <= calib_reset;
      if (calib_reset) begin
        calibrated <= 1'b0; cal_temp <= 16'h0000;
        cell_const <= tmh_pkg::DEF_CELL_X10000;
      end
    end
  end

endmodule : tmh_ctrl

// file: verif/tmh_ctrl_properties.sv
// Checker: controller properties
`timescale 1ns/10ps
module tmh_ctrl_props (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // Observed ports
  input wire logic                  reading_valid,
  input wire logic [15:0]           chart_lo,
  input wire logic [15:0]           chart_hi,
  input wire tmh_pkg::tmh_mode_type mode,
  input wire logic                  hold,
  input wire logic                  clean_msg,
  input wire logic                  activity_led,
  input wire logic                  relay_one_out,
  input wire logic                  relay_two_out,
  input wire logic                  relay_one_high_msg,
  input wire logic                  relay_one_low_msg,
  input wire logic                  relay_two_high_msg,
  input wire logic                  relay_two_low_msg,
  input wire logic [15:0]           analog_out,
  input wire logic [15:0]           serial_value,
  input wire logic [15:0]           chart_point,
  input wire logic [3:0]            chart_div,
  input wire logic [5:0]            trend_mins,
  input wire logic [5:0]            trend_fill
);
  // ----------------------------------------
  // One clock domain, reset disables all
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  powerup_exit_a: assert property (mode == tmh_pkg::TMH_POWERUP |=> mode == tmh_pkg::TMH_MEASURE)
    else $error("powerup stuck");
  log_entry_a: assert property ($changed(mode) && mode == tmh_pkg::TMH_LOGVIEW |-> $past(mode) == tmh_pkg::TMH_MEASURE)
    else $error("bad log entry");
  menu_hold_a: assert property (mode inside {tmh_pkg::TMH_SETUP, tmh_pkg::TMH_CALIB} |-> hold)
    else $error("menu no hold");
  relay_block_a: assert property (hold |-> !relay_one_out && !relay_two_out)
    else $error("relay in hold");
  analog_freeze_a: assert property (hold && $past(hold) |-> analog_out == $past(analog_out))
    else $error("analog moved");
  serial_freeze_a: assert property (hold ##1 hold |-> $stable(serial_value))
    else $error("serial moved");
  clean_led_a: assert property (clean_msg |-> activity_led && !relay_one_out && !relay_two_out)
    else $error("clean led");
  trip_msg_a: assert property (relay_one_high_msg || relay_one_low_msg || relay_two_high_msg
    || relay_two_low_msg |-> activity_led && !(relay_one_high_msg && relay_one_low_msg))
    else $error("trip no led");
  chart_clamp_a: assert property ($changed(chart_point) |-> chart_point >= $past(chart_lo)
    && chart_point <= $past(chart_hi))
    else $error("chart unclamped");
  chart_div_a: assert property (chart_div <= 4'hB)
    else $error("chart div high");
  trend_mins_a: assert property (trend_mins < 6'h3C)
    else $error("trend mins high");
  fill_step_a: assert property (trend_fill <= 6'h3C && (trend_fill == 6'h00
    || trend_fill == $past(trend_fill) || trend_fill == $past(trend_fill) + 6'h01))
    else $error("trend fill jumped");
endmodule : tmh_ctrl_props

bind tmh_ctrl tmh_ctrl_props u_tmh_ctrl_props (.*);

// file: verif/tmh_keypad.sv
// Partner model: operator pressing the front-panel keys
`timescale 1ns/10ps
module tmh_keypad (
  // Clock
  input wire logic  clk,
  // Key levels and passcode
  output logic      log_key,
  output logic      disp_key,
  output logic      setup_req,
  output logic      calib_req,
  output logic      exit_req,
  output logic      code_enable,
  output logic [15:0] code_entry
);
  // Keys idle released
  initial begin
    {log_key, disp_key, setup_req, calib_req, exit_req, code_enable} = 6'h00;
    code_entry = 16'h0000;
  end

  // Hold one key cyc cycles, release, settle
  task automatic press(input int k, input int cyc = 3, input logic en = 1'b0,
                       input logic [15:0] code = 16'h0000);
    @(negedge clk);
    code_enable = en;
    code_entry = code;
    case (k)
      0: log_key = 1'b1;
      1: disp_key = 1'b1;
      2: setup_req = 1'b1;
      3: calib_req = 1'b1;
      default: exit_req = 1'b1;
    endcase
    repeat (cyc) @(negedge clk);
    {log_key, disp_key, setup_req, calib_req, exit_req} = 5'h00;
    code_entry = ~code; // Drop stale code
    repeat (4) @(negedge clk);
  endtask : press
endmodule : tmh_keypad

// file: verif/test_tmh_ctrl.sv
// Testbench for the controller
`timescale 1ns/10ps
module test_tmh_ctrl;
  localparam int LP = 8; // Short long-press so the run stays brief
  logic clk, rst, master_reset, calib_reset, reading_valid, clean_active, rs;
  logic relay_one_trip, relay_two_trip, relay_one_high, relay_two_high;
  logic [15:0] trend_minutes, reading, chart_lo, chart_hi, analog_live;
  wire logic log_key, disp_key, setup_req, calib_req, exit_req, code_enable;
  wire logic [15:0] code_entry;
  tmh_pkg::tmh_mode_type mode, last_mode, exp_q[$];
  tmh_pkg::tmh_disp_type disp;
  logic hold, clean_stop, clean_msg, activity_led, relay_one_out, relay_two_out;
  logic relay_one_high_msg, relay_one_low_msg, relay_two_high_msg, relay_two_low_msg;
  logic chart_restart, trend_div_mark, cfg_cond_auto, manual_temp_comp, relay_one_is_high;
  logic relay_two_is_high, wash_on, backlight_on, code_on, auto_return, ao_four_ma;
  logic calibrated, cal_date_reset;
  logic [15:0] analog_out, serial_value, chart_point, mtc_temp, temp_coef, cell_const;
  logic [15:0] relay_one_setpoint, relay_two_setpoint, relay_one_dead_band;
  logic [15:0] relay_two_dead_band, ao1_span_hi, ao2_span_hi, cal_temp, setup_code;
  logic [15:0] trend_mean [60], trend_max [60], trend_min [60];
  logic [3:0] chart_div, contrast;
  logic [9:0] trend_hours;
  logic [5:0] trend_mins, trend_fill;
  int error_cnt, cmp_count, seed;

  tmh_ctrl #(.LONG_PRESS_CYC(LP), .CHART_DIV_CYC(16), .CYC_PER_MIN(120)) u_tmh_ctrl (.*);
  tmh_keypad u_tmh_keypad (.*);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // Idle cycles, random readings if asked
  task automatic spin(input int n, input logic rnd);
    repeat (n) begin
      @(negedge clk);
      if (rnd) reading = 16'($random(seed));
    end
  endtask : spin

  // Scoreboard: mode change against oldest note
  always @(negedge clk) begin
    if (!rst && mode !== last_mode) begin
      if (exp_q.size() == 0) check("mode unexpected", mode, last_mode);
      else check("mode", mode, exp_q.pop_front());
      last_mode = mode;
    end
  end

  // Restart pulse is one cycle wide, so latch it
  always @(posedge clk) if (chart_restart === 1'b1) rs <= 1'b1;

  // Watchdog, about eight times the run
  initial begin
    #125000;
    error_cnt++;
    summarize();
  end

  initial begin
    seed = 32'h5a02;
    {error_cnt, cmp_count} = 64'h0;
    last_mode = tmh_pkg::TMH_POWERUP;
    {master_reset, calib_reset, reading_valid, clean_active, rs} = 5'h00;
    {relay_one_trip, relay_two_trip, relay_one_high, relay_two_high} = 4'h0;
    {trend_minutes, reading, analog_live} = 48'h0003_0000_0000;
    {chart_lo, chart_hi} = 32'h03E8_0BB8;
    rst = 1'b1;
    exp_q.push_back(tmh_pkg::TMH_MEASURE);
    repeat (20) @(negedge clk);
    rst = 1'b0;
    spin(3, 1'b0);
    check("meas cfg", {cfg_cond_auto, manual_temp_comp, mtc_temp, temp_coef},
      {2'h3, tmh_pkg::DEF_MTC_TEMP_X10, tmh_pkg::DEF_TC_X100});
    check("flags", {wash_on, backlight_on, contrast, code_on, auto_return}, 8'h01);
    check("relay cfg", {relay_one_setpoint, relay_one_dead_band, relay_two_setpoint,
      relay_two_dead_band, relay_one_is_high, relay_two_is_high}, {tmh_pkg::DEF_R1_SP_X100,
      tmh_pkg::DEF_R1_DB_X100, tmh_pkg::DEF_R2_SP_X100, tmh_pkg::DEF_R2_DB_X100, 2'h2});
    check("spans", {ao_four_ma, ao1_span_hi, ao2_span_hi},
      {1'b1, tmh_pkg::DEF_AO1_HI_X10, tmh_pkg::DEF_AO2_HI_X10});
    check("cal", {calibrated, cal_temp, cell_const}, {17'h0_0000, tmh_pkg::DEF_CELL_X10000});
    check("code", setup_code, tmh_pkg::DEF_SETUP_CODE);
    $display("Test defaults done");
    // Set-up hold freezes outputs, blocks relays
    {analog_live, reading, reading_valid, relay_one_trip} = {16'h1234, 16'h0456, 2'h3};
    spin(4, 1'b0);
    exp_q.push_back(tmh_pkg::TMH_SETUP);
    u_tmh_keypad.press(2);
    analog_live = 16'h4321;
    spin(6, 1'b1);
    check("hold", {hold, relay_one_out}, 2'h2);
    check("analog", analog_out, 16'h1234);
    check("serial", serial_value, 16'h0456);
    rs = 1'b0;
    exp_q.push_back(tmh_pkg::TMH_MEASURE);
    u_tmh_keypad.press(4);
    check("restart", rs, 1'b1);
    {relay_one_high, relay_two_trip, relay_two_high} = 3'h6;
    spin(3, 1'b0);
    check("trip", {relay_one_out, relay_one_high_msg, relay_two_low_msg, activity_led},
      4'hF);
    $display("Test hold done");
    // Wrong code refused, set-up code opens calibration
    u_tmh_keypad.press(3, 3, 1'b1, 16'h2222);
    exp_q.push_back(tmh_pkg::TMH_CALIB);
    u_tmh_keypad.press(3, 3, 1'b1, 16'h1111);
    check("cal hold", hold, 1'b1);
    exp_q.push_back(tmh_pkg::TMH_MEASURE);
    u_tmh_keypad.press(4);
    // Cleaning, then set-up entered from the cleaning hold
    clean_active = 1'b1;
    spin(4, 1'b0);
    check("clean", {hold, clean_msg, activity_led, relay_one_out, relay_two_out},
      5'h1C);
    exp_q.push_back(tmh_pkg::TMH_SETUP);
    u_tmh_keypad.press(2);
    check("clean stop", {clean_stop, clean_msg, hold}, 3'h5);
    clean_active = 1'b0;
    exp_q.push_back(tmh_pkg::TMH_MEASURE);
    u_tmh_keypad.press(4);
    check("relay back", relay_one_out, 1'b1);
    $display("Test menus done");
    // Log key short, long, return
    u_tmh_keypad.press(0);
    exp_q.push_back(tmh_pkg::TMH_LOGVIEW);
    u_tmh_keypad.press(0, LP + 4);
    exp_q.push_back(tmh_pkg::TMH_MEASURE);
    u_tmh_keypad.press(0);
    u_tmh_keypad.press(1, LP + 4);
    check("disp chart", disp, tmh_pkg::TMH_DISP_CHART);
    u_tmh_keypad.press(1, LP + 4);
    check("disp trend", disp, tmh_pkg::TMH_DISP_TREND);
    // Chart clamps to both limits
    reading = 16'hFFFF;
    spin(20, 1'b0);
    check("clamp hi", chart_point, chart_hi);
    reading = 16'h0000;
    spin(20, 1'b0);
    check("clamp lo", chart_point, chart_lo);
    spin(30, 1'b1);
    $display("Test keys and chart done");
    // Trend duration, clear, fill, shift
    trend_minutes = 16'h9D80;
    spin(2, 1'b0);
    check("672:00", {trend_hours, trend_mins}, 16'hA800);
    trend_minutes = 16'h007D;
    spin(2, 1'b0);
    check("2:05", {trend_hours, trend_mins}, 16'h0085);
    reading = 16'h0777;
    trend_minutes = 16'h0003;
    spin(2, 1'b0);
    check("cleared", trend_fill, 6'h00);
    spin(348, 1'b0);
    reading = 16'h0999;
    spin(18, 1'b0);
    check("fill", trend_fill, 6'h3C);
    check("newest", {trend_mean[59], trend_max[59], trend_min[59]}, 48'h0999_0999_0999);
    check("older", {trend_mean[56], trend_max[56], trend_min[56]}, 48'h0777_0777_0777);
    master_reset = 1'b1;
    spin(1, 1'b0);
    master_reset = 1'b0;
    check("reset fill", trend_fill, 6'h00);
    calib_reset = 1'b1;
    spin(1, 1'b0);
    calib_reset = 1'b0;
    check("cal date", cal_date_reset, 1'b1);
    $display("Test trend and resets done");
    summarize();
  end
endmodule : test_tmh_ctrl
